// >>> rtl/ppgos_pkg.sv
// shared constants, types and register map of the pulse timer
package ppgos_pkg;

    // ========================================================
    // widths
    localparam int CNT_W  = 16;
    localparam int ADDR_W = 4;
    localparam int CCC_W  = 3;

    // ========================================================
    // register word offsets
    localparam logic [ADDR_W-1:0] OFS_COUNT   = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CYCLE   = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_DUTY    = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_MODE    = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_CCC     = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_OUTCTL  = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_PRESCL  = 4'h6;

    // ========================================================
    // field positions
    localparam int MC_OVF_BIT     = 0;
    localparam int MC_MODE_LO     = 2;
    localparam int MC_MODE_HI     = 3;
    localparam int OC_ENABLE_BIT  = 0;
    localparam int OC_INVERT_BIT  = 1;
    localparam int OC_ONESHOT_BIT = 5;
    localparam int OC_TRIG_BIT    = 6;
    localparam int PM_CLK_LO      = 0;
    localparam int PM_CLK_HI      = 1;
    localparam int PM_EDGE_LO     = 4;
    localparam int PM_EDGE_HI     = 5;

    // ========================================================
    // values
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_MAX  = 16'hffff;
    localparam logic [CNT_W-1:0] CYC_RST  = 16'hffff;
    localparam logic [CNT_W-1:0] DUTY_RST = 16'h0000;

    // ========================================================
    // types
    typedef enum logic [1:0] {
        MODE_STOP      = 2'b00,
        MODE_EDGE_CLR  = 2'b01,
        MODE_FREE      = 2'b10,
        MODE_MATCH_CLR = 2'b11
    } ppgos_mode_t;

    typedef enum logic [1:0] {
        EDGE_FALL = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_NONE = 2'b10,
        EDGE_BOTH = 2'b11
    } ppgos_edge_t;

    typedef enum logic [1:0] {
        OS_IDLE    = 2'b00,
        OS_WAIT_ON = 2'b01,
        OS_ACTIVE  = 2'b11
    } ppgos_os_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [CNT_W-1:0]  wdata;
        logic              wr;
        logic              rd;
    } ppgos_bus_t;

endpackage

// >>> rtl/ppgos_prescaler.sv
// count clock tick generator, divide by two to the power sel plus one
`timescale 1ns/1ps
`default_nettype none
module ppgos_prescaler #(
    parameter int DIV_W = 4
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] sel,
    output logic            tick
);
    // ========================================================
    // divider
    // free running on purpose: a start is not aligned to the tick
    logic [DIV_W-1:0] div_reg;
    logic [DIV_W-1:0] mask;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    always_comb begin
        mask = DIV_W'((1 << ({1'b0, sel} + 3'd1)) - 1);
        tick = ((div_reg & mask) == mask);
    end
endmodule
`default_nettype wire

// >>> rtl/ppgos_edge.sv
// valid edge detector for the trigger input
`timescale 1ns/1ps
`default_nettype none
module ppgos_edge
    import ppgos_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        pin,
    input  wire logic        arm,
    input  wire ppgos_edge_t sel,
    output logic             hit
);
    // ========================================================
    // edge compare
    // the previous level is kept while stopped, so an edge made
    // during the stop is seen right after the start
    logic prev_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg <= 1'b0;
        end else if (arm) begin
            prev_reg <= pin;
        end
    end

    always_comb begin
        case (sel)
            EDGE_FALL: hit = prev_reg & ~pin;
            EDGE_RISE: hit = ~prev_reg & pin;
            EDGE_BOTH: hit = prev_reg ^ pin;
            default:   hit = 1'b0;
        endcase
        hit = hit & arm;
    end
endmodule
`default_nettype wire

// >>> rtl/ppgos_timer.sv
// 16-bit timer with pulse generator and one-shot pulse output
// ========================================================
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ppgos_timer
    import ppgos_pkg::*;
#(
    parameter int DIV_W = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire ppgos_bus_t       bus,
    output logic [CNT_W-1:0]      rd_data,
    input  wire logic             trigger_input_pin,
    input  wire logic             second_input_pin,
    output logic                  timer_output_pin,
    output logic                  cycle_match_irq,
    output logic                  duty_match_irq
);
    // ========================================================
    // register state
    logic [CNT_W-1:0] timer_count_value_reg;
    logic [CNT_W-1:0] cycle_compare_reg;
    logic [CNT_W-1:0] duty_compare_reg;
    ppgos_mode_t      mode_reg;
    logic             overflow_flag_reg;
    logic [CCC_W-1:0] capture_compare_control_reg;
    logic             out_enable_reg;
    logic             out_invert_reg;
    logic             oneshot_mode_reg;
    logic [1:0]       clk_sel_reg;
    ppgos_edge_t      edge_sel_reg;

    // ========================================================
    // decode
    logic wr_count;
    logic wr_cycle;
    logic wr_duty;
    logic wr_mode;
    logic wr_ccc;
    logic wr_outctl;
    logic wr_prescl;
    logic rd_count;
    logic running;

    always_comb begin
        wr_count  = bus.wr && (bus.addr == OFS_COUNT);
        wr_cycle  = bus.wr && (bus.addr == OFS_CYCLE);
        wr_duty   = bus.wr && (bus.addr == OFS_DUTY);
        wr_mode   = bus.wr && (bus.addr == OFS_MODE);
        wr_ccc    = bus.wr && (bus.addr == OFS_CCC);
        wr_outctl = bus.wr && (bus.addr == OFS_OUTCTL);
        wr_prescl = bus.wr && (bus.addr == OFS_PRESCL);
        rd_count  = bus.rd && (bus.addr == OFS_COUNT);
        running   = (mode_reg != MODE_STOP);
    end

    // ========================================================
    // count clock
    logic tick_raw;
    logic tick_hold_reg;
    logic tick_eff;

    ppgos_prescaler #(
        .DIV_W (DIV_W)
    ) u_prescaler (
        .clk   (clk),
        .rst_n (rst_n),
        .sel   (clk_sel_reg),
        .tick  (tick_raw)
    );

    // a tick that meets a count read is held one cycle, so the read
    // sees a stable value and the count still advances afterwards
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_hold_reg <= 1'b0;
        end else begin
            tick_hold_reg <= tick_raw && rd_count;
        end
    end

    always_comb begin
        tick_eff = ((tick_raw && !rd_count) || tick_hold_reg) && running;
    end

    // ========================================================
    // trigger input
    logic edge_hit;
    logic soft_trig;
    logic restart;

    ppgos_edge u_edge (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (trigger_input_pin),
        .arm   (running),
        .sel   (edge_sel_reg),
        .hit   (edge_hit)
    );

    always_comb begin
        soft_trig = wr_outctl && bus.wdata[OC_TRIG_BIT] && running && oneshot_mode_reg;
        // the pin restarts in soft one-shot use as well
        restart = soft_trig
               || (edge_hit && (mode_reg == MODE_EDGE_CLR || oneshot_mode_reg));
    end

    // ========================================================
    // compare
    logic wrapped_reg;
    logic cycle_hit;
    logic duty_hit;
    logic cycle_match;
    logic duty_match;
    logic wrap_now;

    // a zero compare must not match straight after a clear or start,
    // only once the count has come round past the top
    always_comb begin
        cycle_hit = (timer_count_value_reg == cycle_compare_reg)
                 && (timer_count_value_reg != CNT_ZERO || wrapped_reg);
        duty_hit  = (timer_count_value_reg == duty_compare_reg)
                 && (timer_count_value_reg != CNT_ZERO || wrapped_reg);
        cycle_match = tick_eff && cycle_hit && !restart;
        duty_match  = tick_eff && duty_hit && !restart;
        wrap_now    = tick_eff && !restart && (timer_count_value_reg == CNT_MAX);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrapped_reg <= 1'b0;
        end else if (!running || restart) begin
            wrapped_reg <= 1'b0;
        end else if (wrap_now) begin
            wrapped_reg <= 1'b1;
        end
    end

    // ========================================================
    // counter
    // a write to the count word is ignored: the count is read only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_count_value_reg <= CNT_ZERO;
        end else if (!running) begin
            timer_count_value_reg <= CNT_ZERO;
        end else if (restart) begin
            timer_count_value_reg <= CNT_ZERO;
        end else if (tick_eff) begin
            if (mode_reg == MODE_MATCH_CLR && cycle_hit) begin
                timer_count_value_reg <= CNT_ZERO;
            end else begin
                // keeps counting after a one-shot pulse has ended
                timer_count_value_reg <= timer_count_value_reg + CNT_ONE;
            end
        end
    end

    // ========================================================
    // overflow flag
    // software clears it by writing zero; a wrap in that cycle wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overflow_flag_reg <= 1'b0;
        end else if (wrap_now) begin
            overflow_flag_reg <= 1'b1;
        end else if (wr_mode && !bus.wdata[MC_OVF_BIT]) begin
            overflow_flag_reg <= 1'b0;
        end
    end

    // ========================================================
    // control registers
    // mode is always writable so that software can stop the timer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= MODE_STOP;
        end else if (wr_mode) begin
            mode_reg <= ppgos_mode_t'(bus.wdata[MC_MODE_HI:MC_MODE_LO]);
        end
    end

    // these only take writes while stopped, a running timer keeps
    // its setup rather than glitching mid pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            capture_compare_control_reg <= '0;
        end else if (wr_ccc && !running) begin
            capture_compare_control_reg <= bus.wdata[CCC_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_enable_reg   <= 1'b0;
            out_invert_reg   <= 1'b0;
            oneshot_mode_reg <= 1'b0;
        end else if (wr_outctl && !running) begin
            out_enable_reg   <= bus.wdata[OC_ENABLE_BIT];
            out_invert_reg   <= bus.wdata[OC_INVERT_BIT];
            oneshot_mode_reg <= bus.wdata[OC_ONESHOT_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_sel_reg  <= '0;
            edge_sel_reg <= EDGE_FALL;
        end else if (wr_prescl && !running) begin
            clk_sel_reg  <= bus.wdata[PM_CLK_HI:PM_CLK_LO];
            edge_sel_reg <= ppgos_edge_t'(bus.wdata[PM_EDGE_HI:PM_EDGE_LO]);
        end
    end

    // compare words are kept across a stop here, though software
    // may not count on that
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cycle_compare_reg <= CYC_RST;
        end else if (wr_cycle) begin
            cycle_compare_reg <= bus.wdata[CNT_W-1:0];
        end
    end

    // the duty word is never loaded from the counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            duty_compare_reg <= DUTY_RST;
        end else if (wr_duty) begin
            duty_compare_reg <= bus.wdata[CNT_W-1:0];
        end
    end

    // ========================================================
    // one-shot sequencer
    ppgos_os_t os_reg;
    logic      duty_first;
    logic      on_match;
    logic      off_match;

    always_comb begin
        duty_first = (duty_compare_reg < cycle_compare_reg);
        on_match   = duty_first ? duty_match : cycle_match;
        off_match  = duty_first ? cycle_match : duty_match;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            os_reg <= OS_IDLE;
        end else if (!running || !oneshot_mode_reg) begin
            os_reg <= OS_IDLE;
        end else if (restart) begin
            os_reg <= OS_WAIT_ON;
        end else begin
            case (os_reg)
                OS_IDLE: begin
                    os_reg <= OS_IDLE;
                end
                OS_WAIT_ON: begin
                    if (on_match) begin
                        os_reg <= OS_ACTIVE;
                    end
                end
                OS_ACTIVE: begin
                    if (off_match) begin
                        os_reg <= OS_IDLE;
                    end
                end
                default: begin
                    os_reg <= OS_IDLE;
                end
            endcase
        end
    end

    // ========================================================
    // pulse generator level
    logic run_d_reg;
    logic ppg_level_reg;
    logic ppg_mode;

    always_comb begin
        ppg_mode = (mode_reg == MODE_MATCH_CLR) && !oneshot_mode_reg;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_d_reg <= 1'b0;
        end else begin
            run_d_reg <= running;
        end
    end

    // high from each period start to the duty match
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ppg_level_reg <= 1'b0;
        end else if (!ppg_mode) begin
            ppg_level_reg <= 1'b0;
        end else if (running && !run_d_reg) begin
            ppg_level_reg <= 1'b1;
        end else if (cycle_match) begin
            ppg_level_reg <= 1'b1;
        end else if (duty_match) begin
            ppg_level_reg <= 1'b0;
        end
    end

    // ========================================================
    // outputs
    logic level;

    always_comb begin
        level = ppg_level_reg || (os_reg == OS_ACTIVE);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_output_pin <= 1'b0;
        end else begin
            timer_output_pin <= out_enable_reg && (level ^ out_invert_reg);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cycle_match_irq <= 1'b0;
            duty_match_irq  <= 1'b0;
        end else begin
            cycle_match_irq <= cycle_match;
            duty_match_irq  <= duty_match;
        end
    end

    // ========================================================
    // read port
    // second input pin has no use without capture, read as a level
    logic [CNT_W-1:0] rd_next;

    always_comb begin
        rd_next = '0;
        case (bus.addr)
            OFS_COUNT: begin
                rd_next = timer_count_value_reg;
            end
            OFS_CYCLE: begin
                rd_next = cycle_compare_reg;
            end
            OFS_DUTY: begin
                rd_next = duty_compare_reg;
            end
            OFS_MODE: begin
                rd_next[MC_OVF_BIT]            = overflow_flag_reg;
                rd_next[MC_MODE_HI:MC_MODE_LO] = mode_reg;
            end
            OFS_CCC: begin
                rd_next[CCC_W-1:0] = capture_compare_control_reg;
            end
            OFS_OUTCTL: begin
                rd_next[OC_ENABLE_BIT]  = out_enable_reg;
                rd_next[OC_INVERT_BIT]  = out_invert_reg;
                rd_next[OC_ONESHOT_BIT] = oneshot_mode_reg;
                rd_next[OC_TRIG_BIT]    = 1'b0;
            end
            OFS_PRESCL: begin
                rd_next[PM_CLK_HI:PM_CLK_LO]   = clk_sel_reg;
                rd_next[PM_EDGE_HI:PM_EDGE_LO] = edge_sel_reg;
                rd_next[CNT_W-1]               = second_input_pin;
            end
            default: begin
                rd_next = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (bus.rd) begin
            rd_data <= rd_next;
        end else begin
            rd_data <= '0;
        end
    end

    // unused decode kept visible for the count word
    logic unused_wr_count;
    always_comb begin
        unused_wr_count = wr_count;
    end
endmodule
`default_nettype wire

// >>> sim/ppgos_monitor.sv
// port checker for the pulse timer
`timescale 1ns/1ps
`default_nettype none
module ppgos_monitor
    import ppgos_pkg::*;
#(
    parameter int DIV_W = 4
) (
    input wire logic             clk,
    input wire logic             rst_n,
    input wire ppgos_bus_t       bus,
    input wire logic [CNT_W-1:0] rd_data,
    input wire logic             trigger_input_pin,
    input wire logic             second_input_pin,
    input wire logic             timer_output_pin,
    input wire logic             cycle_match_irq,
    input wire logic             duty_match_irq
);
    // ========================================================
    // shadow of what software wrote; output control and prescaler words only land while stopped
    logic [1:0]       mode_q;
    logic [CNT_W-1:0] cyc_q;
    logic [CNT_W-1:0] duty_q;
    logic [CNT_W-1:0] oc_q;
    logic [CNT_W-1:0] pm_q;
    logic [1:0]       stop_cnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= 2'h0;
            cyc_q  <= CYC_RST;
            duty_q <= DUTY_RST;
            oc_q   <= 16'h0000;
            pm_q   <= 16'h0000;
        end else if (bus.wr) begin
            if (bus.addr == OFS_MODE) mode_q <= bus.wdata[MC_MODE_HI:MC_MODE_LO];
            if (bus.addr == OFS_CYCLE) cyc_q <= bus.wdata;
            if (bus.addr == OFS_DUTY) duty_q <= bus.wdata;
            if (bus.addr == OFS_OUTCTL && mode_q == MODE_STOP) oc_q <= bus.wdata & 16'h0023;
            if (bus.addr == OFS_PRESCL && mode_q == MODE_STOP) pm_q <= bus.wdata & 16'h0033;
        end
    end
    // settle time after a stop, a match in flight may still emerge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) stop_cnt <= 2'h0;
        else if (mode_q != MODE_STOP) stop_cnt <= 2'h0;
        else if (stop_cnt != 2'h3) stop_cnt <= stop_cnt + 2'h1;
    end
    // ========================================================
    // assertions
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_cycle_readback: assert property (bus.rd && bus.addr == OFS_CYCLE |=> rd_data == cyc_q)
        else $error("cycle readback differs");
    a_duty_kept: assert property (bus.rd && bus.addr == OFS_DUTY |=> rd_data == duty_q)
        else $error("duty readback differs");
    a_trig_reads_zero: assert property (bus.rd && bus.addr == OFS_OUTCTL |=> !rd_data[OC_TRIG_BIT])
        else $error("trigger bit read as one");
    a_outctl_locked: assert property (bus.rd && bus.addr == OFS_OUTCTL |=> (rd_data & 16'h0023) == oc_q)
        else $error("output control changed while running");
    a_prescl_locked: assert property (bus.rd && bus.addr == OFS_PRESCL |=> (rd_data & 16'h0033) == pm_q)
        else $error("prescaler changed while running");
    a_stopped_quiet: assert property (stop_cnt == 2'h3 |-> !cycle_match_irq && !duty_match_irq)
        else $error("match pulse while stopped");
    a_stopped_zero: assert property (stop_cnt == 2'h3 && bus.rd && bus.addr == OFS_COUNT
        |=> rd_data == CNT_ZERO)
        else $error("count not zero while stopped");
    a_irq_single: assert property ($rose(cycle_match_irq) |=> !cycle_match_irq)
        else $error("cycle match pulse too long");
    // the pin trails its match pulse by one clock
    a_oneshot_on: assert property (mode_q != MODE_STOP && $past(mode_q) != MODE_STOP
        && oc_q[OC_ONESHOT_BIT] && !oc_q[OC_INVERT_BIT] && $rose(timer_output_pin)
        |-> (duty_q < cyc_q ? $past(duty_match_irq) : $past(cycle_match_irq)))
        else $error("one-shot output rose without its match");
    a_pulse_off: assert property (mode_q == MODE_MATCH_CLR && !oc_q[OC_ONESHOT_BIT] && !oc_q[OC_INVERT_BIT]
        && $fell(timer_output_pin) |-> $past(duty_match_irq))
        else $error("pulse output fell without duty match");
    c_pulse: cover property ($rose(timer_output_pin));
    c_duty: cover property (duty_match_irq);
    c_stop_read: cover property (stop_cnt == 2'h3 && bus.rd && bus.addr == OFS_COUNT);
endmodule
bind ppgos_timer ppgos_monitor #(.DIV_W(DIV_W)) i_mon (.clk(clk), .rst_n(rst_n), .bus(bus), .rd_data(rd_data),
    .trigger_input_pin(trigger_input_pin), .second_input_pin(second_input_pin),
    .timer_output_pin(timer_output_pin), .cycle_match_irq(cycle_match_irq), .duty_match_irq(duty_match_irq));
`default_nettype wire

// >>> sim/testbench.sv
// self-checking bench for the pulse timer
`timescale 1ns/1ps
`default_nettype none
module testbench
    import ppgos_pkg::*;
;
    logic             clk;
    logic             rst_n;
    ppgos_bus_t       bus;
    logic [CNT_W-1:0] rd_data;
    logic             trig;
    logic             sec;
    logic             pin;
    logic             cyc_irq;
    logic             duty_irq;
    int               error_cnt;
    int               n_compared;
    int               irq_seen;
    logic [15:0]      v;
    logic [15:0]      h;
    logic [15:0]      p;
    logic [15:0]      c1;
    ppgos_timer #(.DIV_W(4)) i_dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rd_data(rd_data),
        .trigger_input_pin(trig), .second_input_pin(sec), .timer_output_pin(pin),
        .cycle_match_irq(cyc_irq), .duty_match_irq(duty_irq));
    // ========================================================
    // clock and access tasks
    initial clk = 1'b0;
    always #2.5 clk = ~clk;
    always @(negedge clk) if (cyc_irq === 1'b1 || duty_irq === 1'b1) irq_seen++;
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk) bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk) bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk) bus.rd <= 1'b0;
        #1 d = rd_data;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input logic [3:0] a, input logic [15:0] e, input string n);
        logic [15:0] d;
        rd(a, d);
        chk(n, e, d);
    endtask
    // stop first: the ccc, output control and prescaler words are ignored while running
    task automatic setup(input logic [15:0] cy, input logic [15:0] du, input logic [15:0] oc,
                         input logic [15:0] pm, input logic [15:0] md);
        wr(OFS_MODE, 16'h0000);
        wr(OFS_CCC, 16'h0000);
        wr(OFS_CYCLE, cy);
        wr(OFS_DUTY, du);
        wr(OFS_OUTCTL, oc);
        wr(OFS_PRESCL, pm);
        wr(OFS_MODE, md);
    endtask
    task automatic hi_cnt(input int n, output logic [15:0] hh);
        hh = 16'h0000;
        repeat (n) begin
            @(negedge clk);
            hh = hh + {15'h0000, pin};
        end
    endtask
    task automatic drive_trig(input logic lv);
        @(posedge clk) trig <= lv;
    endtask
    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // bench runs about 1000 clocks, well inside the 10000-clock limit
    initial begin
        #50000;
        error_cnt++;
        final_report();
    end
    // ========================================================
    // tests
    initial begin : main
        logic [15:0] cv [3];
        logic [15:0] dv [3];
        logic [1:0]  es;
        cv = '{16'h000a, 16'h0004, 16'h0002};
        dv = '{16'h0004, 16'h000a, 16'h0001};
        error_cnt = 0;
        n_compared = 0;
        irq_seen = 0;
        rst_n = 1'b0;
        bus = '0;
        trig = 1'b0;
        sec = 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rchk(OFS_CYCLE, CYC_RST, "cycle reset");
        rchk(OFS_DUTY, DUTY_RST, "duty reset");
        rchk(OFS_MODE, 16'h0000, "mode reset");
        rchk(OFS_COUNT, CNT_ZERO, "count reset");
        rchk(4'hf, 16'h0000, "unmapped read");
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            setup(cv[i], dv[i], 16'h0021, 16'h0010, 16'h0008);
            wr(OFS_OUTCTL, 16'h0061);
            hi_cnt(60, h);
            chk("soft pulse width", 16'((cv[i] > dv[i] ? cv[i] - dv[i] : dv[i] - cv[i]) * 2), h);
        end
        rchk(OFS_OUTCTL, 16'h0021, "trigger bit reads zero");
        rd(OFS_COUNT, c1);
        repeat (20) @(posedge clk);
        rd(OFS_COUNT, v);
        chk("count keeps running", 16'h0001, {15'h0000, v > c1});
        $display("test soft one-shot done");
        setup(16'h000a, 16'h0004, 16'h0021, 16'h0010, 16'h0008);
        drive_trig(1'b1);
        hi_cnt(60, h);
        chk("pin restarts soft mode", 16'h000c, h);
        drive_trig(1'b0);
        sec <= 1'b1;
        wr(OFS_PRESCL, 16'h0003);
        rchk(OFS_PRESCL, 16'h8010, "prescaler locked");
        rd(OFS_COUNT, v);
        rchk(OFS_DUTY, 16'h0004, "duty after count read");
        sec <= 1'b0;
        $display("test pin in soft mode done");
        for (int s = 0; s < 4; s++) begin
            es = 2'(s);
            setup(16'h000a, 16'h0004, 16'h0021, {10'h000, es, 4'h0}, 16'h0004);
            drive_trig(1'b1);
            hi_cnt(60, h);
            chk("rising edge pulse", (es == EDGE_RISE || es == EDGE_BOTH) ? 16'h000c : 16'h0000, h);
            drive_trig(1'b0);
            hi_cnt(60, h);
            chk("falling edge pulse", (es == EDGE_FALL || es == EDGE_BOTH) ? 16'h000c : 16'h0000, h);
        end
        $display("test external one-shot done");
        for (int k = 0; k < 2; k++) begin
            setup(16'h0005, 16'h0001, {14'h0000, k[0], 1'b1}, 16'h0000, 16'h000c);
            p = 16'h0000;
            while (cyc_irq !== 1'b1 && p < 16'd100) begin
                @(negedge clk);
                p++;
            end
            p = 16'h0000;
            h = 16'h0000;
            do begin
                @(negedge clk);
                p++;
                h = h + {15'h0000, pin};
            end while (cyc_irq !== 1'b1 && p < 16'd100);
            chk("pulse period", 16'h000c, p);
            chk("pulse high time", k ? 16'h0008 : 16'h0004, h);
        end
        $display("test pulse mode done");
        wr(OFS_MODE, 16'h0000);
        repeat (4) @(posedge clk);
        c1 = 16'(irq_seen);
        repeat (3) begin
            drive_trig(1'b1);
            drive_trig(1'b0);
        end
        repeat (30) @(posedge clk);
        chk("no match while stopped", c1, 16'(irq_seen));
        rchk(OFS_COUNT, CNT_ZERO, "count stopped");
        $display("test stop done");
        final_report();
    end
endmodule
`default_nettype wire
